// ==== usc_ctl.sv ====
// Firmware-side controller: AXI4-Lite registers driving the device port.
// Assumes one AXI master; resume is timed here for the full hold.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module usc_ctl
    import usc_pkg::*;
#(
    parameter int RESUME_CYCLES = RESUME_CYC
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite
    input wire logic [3:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [3:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // Status
    input wire logic idle_seen_i,
    // Device port
    usc_if.ctl rp
);
    logic aw_q;
    logic w_q;
    logic [3:0] awa_q;
    logic [7:0] wd_q;
    logic [31:0] rtime_q;
    logic rbusy_q;
    logic [7:0] ctl_d;

    assign awready_o = !aw_q && !bvalid_o;
    assign wready_o = !w_q && !bvalid_o;
    wire go = aw_q && w_q && !bvalid_o;
    wire hit = (awa_q == AX_CTL) || (awa_q == AX_CFG) || (awa_q == AX_TIME);
    wire sus_ok = idle_seen_i || !wd_q[CTL_SUSP];
    wire [7:0] cfgw = wd_q & ~(8'h01 << CFG_RSVD);
    wire cfg_ok = !rp.ctl_rd[CTL_EN];
    assign ctl_d = sus_ok ? wd_q : (wd_q & ~(8'h01 << CTL_SUSP));
    wire rdone = rbusy_q && (rtime_q == 32'h0);
    // A firmware write owns the port this cycle; the resume clear waits
    wire rp_take = go && ((awa_q == AX_CTL) || (awa_q == AX_CFG && cfg_ok));

    always_comb
    begin
        rp.wr = 1'b0;
        rp.sel = SEL_CTL;
        rp.wdata = 8'h00;
        if (go && awa_q == AX_CTL)
        begin
            rp.wr = 1'b1;
            rp.wdata = ctl_d;
        end
        else if (go && awa_q == AX_CFG && cfg_ok)
        begin
            rp.wr = 1'b1;
            rp.sel = SEL_CFG;
            rp.wdata = cfgw;
        end
        else if (rdone)
        begin
            rp.wr = 1'b1;
            rp.wdata = rp.ctl_rd & ~(8'h01 << CTL_RESUME) | (8'h01 << CTL_PACKET_PROCESSING_DISABLE);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 4'h0;
            wd_q <= 8'h00;
            bvalid_o <= 1'b0;
            bresp_o <= 2'b00;
            rtime_q <= 32'h0;
            rbusy_q <= 1'b0;
        end
        else
        begin
            if (awvalid_i && awready_o)
            begin
                aw_q <= 1'b1;
                awa_q <= awaddr_i;
            end
            if (wvalid_i && wready_o)
            begin
                w_q <= 1'b1;
                wd_q <= wstrb_i[0] ? wdata_i[7:0] : 8'h00;
            end
            if (go)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_o <= 1'b1;
                bresp_o <= hit ? 2'b00 : 2'b10;
            end
            else if (bvalid_o && bready_i)
                bvalid_o <= 1'b0;
            if (go && awa_q == AX_TIME && wd_q[0])
            begin
                rbusy_q <= 1'b1;
                rtime_q <= 32'(RESUME_CYCLES);
            end
            else if (rdone)
            begin
                if (!rp_take)
                    rbusy_q <= 1'b0;
            end
            else if (rbusy_q)
                rtime_q <= rtime_q - 32'h1;
        end
    end

    // Read channel: one cycle latency
    wire [31:0] rsel =
        (araddr_i == AX_CTL) ? {24'h0, rp.ctl_rd} :
        (araddr_i == AX_CFG) ? {24'h0, rp.cfg_rd} :
        (araddr_i == AX_STAT) ? {31'h0, rbusy_q} : 32'h0;
    wire rhit = (araddr_i == AX_CTL) || (araddr_i == AX_CFG) ||
        (araddr_i == AX_STAT) || (araddr_i == AX_TIME);
    assign arready_o = !rvalid_o;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0;
            rresp_o <= 2'b00;
        end
        else if (arvalid_i && arready_o)
        begin
            rvalid_o <= 1'b1;
            rdata_o <= rsel;
            rresp_o <= rhit ? 2'b00 : 2'b10;
        end
        else if (rvalid_o && rready_i)
            rvalid_o <= 1'b0;
    end
endmodule : usc_ctl
`default_nettype wire

// ==== usc_pkg.sv ====
// Package for the USB engine control/configuration block.
// Assumes a single 100 MHz clock domain shared by both ends.
`default_nettype none
package usc_pkg;
    // Control register bit positions
    localparam int CTL_PPRST = 6;
    localparam int CTL_SE0 = 5;
    localparam int CTL_PACKET_PROCESSING_DISABLE = 4;
    localparam int CTL_EN = 3;
    localparam int CTL_RESUME = 2;
    localparam int CTL_SUSP = 1;
    // Configuration register bit positions
    localparam int CFG_EYE = 7;
    localparam int CFG_RSVD = 6;
    localparam int CFG_PUEN = 4;
    localparam int CFG_TRDIS = 3;
    localparam int CFG_FULL_SPEED_SELECT = 2;
    localparam int CFG_PPB_LO = 0;
    // Writable masks and reset values
    localparam logic [7:0] CTL_WMASK = 8'h4e;
    localparam logic [7:0] CFG_WMASK = 8'hdf;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Device-side register selector
    localparam logic [0:0] SEL_CTL = 1'b0;
    localparam logic [0:0] SEL_CFG = 1'b1;
    // AXI4-Lite map of the controller
    localparam logic [3:0] AX_CTL = 4'h0;
    localparam logic [3:0] AX_CFG = 4'h4;
    localparam logic [3:0] AX_STAT = 4'h8;
    localparam logic [3:0] AX_TIME = 4'hc;
    // Resume hold time
    localparam int RESUME_MS = 10;
    localparam int CLK_MHZ = 100;
    localparam int RESUME_CYC = RESUME_MS * 1000 * CLK_MHZ;
    // Ping-pong modes
    typedef enum logic [1:0] {
        PP_OFF = 2'b00,
        PP_EP0_OUT = 2'b01,
        PP_ALL = 2'b10,
        PP_EP1_15 = 2'b11
    } usc_pp_t;
endpackage : usc_pkg
`default_nettype wire

// ==== usc_if.sv ====
// Register port between controller and the engine control block.
// Assumes both ends clocked by the same clock.
`default_nettype none
interface usc_if;
    logic wr;
    logic sel;
    logic [7:0] wdata;
    logic [7:0] ctl_rd;
    logic [7:0] cfg_rd;
    modport dev (input wr, sel, wdata, output ctl_rd, cfg_rd);
    modport ctl (output wr, sel, wdata, input ctl_rd, cfg_rd);
endinterface : usc_if
`default_nettype wire

// ==== usc_sync.sv ====
// Two-flop level synchroniser.
// Assumes an asynchronous input level.
`default_nettype none
module usc_sync
    import usc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_q;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_q <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            s1_q <= d_i;
            q_o <= s1_q;
        end
    end
endmodule : usc_sync
`default_nettype wire

// ==== usc_dev.sv ====
// Engine control and configuration registers with their effects on the link.
// Assumes the controller writes through the interface; pins are pad-level.
//
// Operation
// - Pointer reset forces even bank select
// - Pointer reset sticky, ignored without ping-pong
// - Live flag shows single-ended zero
// - SETUP sets packet disable, halts processing
// - Packet disable only cleared by write
// - Pending transfer events stay queued
// - Enable bit attaches and activates module
// - Enable refused without valid clock
// - Resume bit drives resume; hold 10 ms
// - Suspend stops engine clock
// - Suspended stays attached, outputs idle
// - Suspend only after idle interrupt
// - Eye pattern test enable bit
// - Reserved bit written zero, others read zero
// - Pull-up on D+ full, D- low
// - Pull-up ignored when transceiver off
// - Transceiver disable bit, reset zero
// - Speed bit selects edge rate
// - Ping-pong mode field encoding
// - Configure before enable, never after
// - Enabling clears pointer indicators
// - Disabled module ignores other controls
`default_nettype none
module usc_dev
    import usc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    usc_if.dev rp,
    // Engine side
    input wire logic clk_ok_i,
    input wire logic se0_i,
    input wire logic setup_tok_i,
    // Control outputs
    output logic attach_o,
    output logic pkt_run_o,
    output logic pp_force_even_o,
    output logic pp_ind_clr_o,
    output logic resume_o,
    output logic sie_clk_en_o,
    output logic tx_idle_o,
    output logic eye_o,
    output logic xcvr_en_o,
    output logic full_speed_o,
    output logic pu_dp_o,
    output logic pu_dm_o,
    output usc_pp_t pp_mode_o
);
    logic [7:0] ctl_q;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic se0_s;
    logic en_q;
    logic en_rise_q;
    logic en_rise_d;

    // Write decode of the register port
    logic wr_ctl;
    logic wr_cfg;
    logic en;
    logic susp;
    logic pp_used;
    logic pkt_set;
    logic pkt_clr;
    logic en_wr;

    usc_sync u_se0 (.clk_i(clk_i), .rst_i(rst_i), .d_i(se0_i), .q_o(se0_s));

    assign wr_ctl = rp.wr && (rp.sel == SEL_CTL);
    assign wr_cfg = rp.wr && (rp.sel == SEL_CFG);
    assign en = ctl_q[CTL_EN];
    assign susp = en && ctl_q[CTL_SUSP];
    assign pp_used = (cfg_q[CFG_PPB_LO+:2] != PP_OFF);
    assign pkt_set = en && setup_tok_i;
    assign pkt_clr = wr_ctl && !rp.wdata[CTL_PACKET_PROCESSING_DISABLE];
    // enable needs clock
    // A refused enable leaves the module detached
    assign en_wr = rp.wdata[CTL_EN] && clk_ok_i;
    assign cfg_d = wr_cfg ? (rp.wdata & CFG_WMASK) : cfg_q;
    assign en_rise_d = en && !en_q;

    logic [7:0] ctl_d;
    always_comb
    begin
        ctl_d = ctl_q;
        if (wr_ctl)
        begin
            ctl_d = (rp.wdata & CTL_WMASK) | (ctl_q & ~CTL_WMASK);
            ctl_d[CTL_EN] = en_wr;
        end
        if (pkt_set)
            ctl_d[CTL_PACKET_PROCESSING_DISABLE] = 1'b1;
        else if (pkt_clr)
            ctl_d[CTL_PACKET_PROCESSING_DISABLE] = 1'b0;
        ctl_d[CTL_SE0] = 1'b0;
        ctl_d[7] = 1'b0;
        ctl_d[0] = 1'b0;
    end

    // Control bits; ctl_d already folds in the hardware set of the flag
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ctl_q <= CTL_RESET;
        else
            ctl_q <= ctl_d;
    end

    // Configuration bits; the controller keeps them still while enabled
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cfg_q <= CFG_RESET;
        else
            cfg_q <= cfg_d;
    end

    // Enable history for the one-cycle pointer clear
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            en_q <= 1'b0;
            en_rise_q <= 1'b0;
        end
        else
        begin
            en_q <= en;
            en_rise_q <= en_rise_d;
        end
    end

    assign rp.ctl_rd = ctl_q | ({7'h00, se0_s} << CTL_SE0);
    assign rp.cfg_rd = cfg_q;

    assign attach_o = en;
    // halt processing; status queue untouched here
    assign pkt_run_o = en && !ctl_q[CTL_PACKET_PROCESSING_DISABLE] && !susp;
    // force even bank, only with ping-pong
    assign pp_force_even_o = en && ctl_q[CTL_PPRST] && pp_used;
    assign pp_ind_clr_o = en_rise_q;
    assign resume_o = en && ctl_q[CTL_RESUME];
    assign sie_clk_en_o = en && !susp;
    assign tx_idle_o = susp && !resume_o;
    // Pad-facing controls come from flip-flops so that decode glitches
    // never reach the transceiver or the pull-up switches.
    logic eye_d;
    logic xcvr_d;
    logic fs_d;
    logic pu;
    usc_pp_t pp_mode_d;
    assign eye_d = en && cfg_q[CFG_EYE];
    assign xcvr_d = !cfg_q[CFG_TRDIS];
    assign fs_d = cfg_q[CFG_FULL_SPEED_SELECT];
    // Pull-up only with the transceiver on; gating by enable means a
    // detached device stops loading the bus one clock after attach_o falls.
    assign pu = en && cfg_q[CFG_PUEN] && xcvr_d;
    assign pp_mode_d = usc_pp_t'(cfg_q[CFG_PPB_LO+:2]);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            eye_o <= 1'b0;
            xcvr_en_o <= !CFG_RESET[CFG_TRDIS];
            full_speed_o <= CFG_RESET[CFG_FULL_SPEED_SELECT];
            pu_dp_o <= 1'b0;
            pu_dm_o <= 1'b0;
            pp_mode_o <= PP_OFF;
        end
        else
        begin
            eye_o <= eye_d;
            xcvr_en_o <= xcvr_d;
            full_speed_o <= fs_d;
            pu_dp_o <= pu && fs_d;
            pu_dm_o <= pu && !fs_d;
            pp_mode_o <= pp_mode_d;
        end
    end
endmodule : usc_dev
`default_nettype wire

// ==== usc_chk_assertions.sv ====
// Checker for the register port between controller and device.
// Assumes one clock; the bench places it beside the port instance.
`default_nettype none
module usc_chk
    import usc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr,
    input wire logic sel,
    input wire logic [7:0] wdata,
    input wire logic [7:0] ctl_rd,
    input wire logic [7:0] cfg_rd
);
    wire ctl_wr = wr && sel == SEL_CTL;
    wire cfg_wr = wr && sel == SEL_CFG;
    wire en_wr = ctl_wr && wdata[CTL_EN];
    wire rsm_wr = ctl_wr && wdata[CTL_RESUME];
    wire clr_wr = ctl_wr && !wdata[CTL_PACKET_PROCESSING_DISABLE];
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_cfg_open;
        cfg_wr && !ctl_rd[CTL_EN];
    endsequence
    sequence s_ctl_on;
        ctl_wr ##1 ctl_rd[CTL_EN];
    endsequence
    property p_unused;
        ctl_rd[7] == 1'b0 && ctl_rd[0] == 1'b0 && cfg_rd[5] == 1'b0;
    endproperty
    property p_cfg_wr;
        s_cfg_open |=> cfg_rd == ($past(wdata) & CFG_WMASK);
    endproperty
    property p_cfg_lock;
        ctl_rd[CTL_EN] |-> !cfg_wr;
    endproperty
    property p_cfg_hold;
        !wr |=> $stable(cfg_rd);
    endproperty
    property p_ppr_wr;
        s_ctl_on |-> ctl_rd[CTL_PPRST] == $past(wdata[CTL_PPRST]);
    endproperty
    property p_ppr_hold;
        ctl_rd[CTL_PPRST] && !wr |=> ctl_rd[CTL_PPRST];
    endproperty
    property p_pkt_hold;
        ctl_rd[CTL_PACKET_PROCESSING_DISABLE] && !clr_wr |=> ctl_rd[CTL_PACKET_PROCESSING_DISABLE];
    endproperty
    property p_en_rise;
        $rose(ctl_rd[CTL_EN]) |-> $past(en_wr);
    endproperty
    property p_rsm_rise;
        $rose(ctl_rd[CTL_RESUME]) |-> $past(rsm_wr);
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set");
    a_cfg_wr: assert property (p_cfg_wr) else $error("config not stored");
    a_cfg_lock: assert property (p_cfg_lock) else $error("config changed");
    a_cfg_hold: assert property (p_cfg_hold) else $error("config drift");
    a_ppr_wr: assert property (p_ppr_wr) else $error("pointer reset lost");
    a_ppr_hold: assert property (p_ppr_hold) else $error("pointer reset dropped");
    a_pkt_hold: assert property (p_pkt_hold) else $error("packet flag dropped");
    a_en_rise: assert property (p_en_rise) else $error("enable without write");
    a_rsm_rise: assert property (p_rsm_rise) else $error("resume without write");
endmodule : usc_chk
`default_nettype wire

// ==== usb_sie_control_config_tb.sv ====
// Bench joining controller and device across the register port.
// Assumes AXI-Lite stimulus and directly driven engine inputs.
`default_nettype none
module usb_sie_control_config_tb
    import usc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RS = 20;
    typedef struct {logic [7:0] cfg; logic [6:0] exp;} usc_row_t;
    usc_row_t rows [4] = '{'{8'h14, 7'h38}, '{8'h11, 7'h25}, '{8'h1e, 7'h12}, '{8'h87, 7'h73}};
    logic clk_i = 0, rst_i = 1, clk_ok = 0, se0 = 0, setup = 0, idle = 0;
    logic [3:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, rv;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, br, rr;
    logic attach, pkt_run, pp_even, pp_clr, resume, sie_clk, tx_idle, eye, xcvr, fs, dp, dm;
    usc_pp_t pp_mode;
    int err_total = 0, comparisons = 0, clr_n = 0;
    usc_if usc_if_inst();
    usc_dev usc_dev_inst(.clk_i(clk_i), .rst_i(rst_i), .rp(usc_if_inst), .clk_ok_i(clk_ok),
        .se0_i(se0), .setup_tok_i(setup), .attach_o(attach), .pkt_run_o(pkt_run),
        .pp_force_even_o(pp_even), .pp_ind_clr_o(pp_clr), .resume_o(resume),
        .sie_clk_en_o(sie_clk), .tx_idle_o(tx_idle), .eye_o(eye), .xcvr_en_o(xcvr),
        .full_speed_o(fs), .pu_dp_o(dp), .pu_dm_o(dm), .pp_mode_o(pp_mode));
    usc_ctl #(.RESUME_CYCLES(RS)) usc_ctl_inst(.clk_i(clk_i), .rst_i(rst_i), .awaddr_i(awaddr),
        .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf),
        .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
        .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
        .idle_seen_i(idle), .rp(usc_if_inst));
    usc_chk usc_chk_inst(.clk_i(clk_i), .rst_i(rst_i), .wr(usc_if_inst.wr),
        .sel(usc_if_inst.sel), .wdata(usc_if_inst.wdata), .ctl_rd(usc_if_inst.ctl_rd),
        .cfg_rd(usc_if_inst.cfg_rd));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (pp_clr === 1'b1) clr_n <= clr_n + 1;
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task summarize;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    task tmo;
        err_total++;
        $display("[FAIL] %0t timeout", $time);
        summarize();
    endtask : tmo
    task ax_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= 32'(d);
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (int n = 0; n < 40; n++)
        begin
            @(posedge clk_i);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1)
            begin
                br = bresp;
                bready <= 0;
                return;
            end
        end
        tmo();
    endtask : ax_wr
    task ax_rd(input logic [3:0] a);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (int n = 0; n < 40; n++)
        begin
            @(posedge clk_i);
            if (arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1)
            begin
                rv = rdata;
                rr = rresp;
                rready <= 0;
                return;
            end
        end
        tmo();
    endtask : ax_rd
    initial
    begin
        int n;
        int n0;
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        ax_rd(AX_CTL);
        chk(rv, 0, "ctl reset");
        ax_rd(AX_CFG);
        chk(rv, 0, "cfg reset");
        chk(32'({attach, xcvr, pkt_run}), 2, "reset outs");
        ax_wr(AX_CTL, 8'h04);
        chk(32'(resume), 0, "resume while off");
        ax_wr(AX_CTL, 8'h08);
        ax_rd(AX_CTL);
        chk(32'({rv[3], attach}), 0, "enable no clock");
        @(posedge clk_i);
        clk_ok <= 1;
        $display("reset and refusal done");
        foreach (rows[i])
        begin
            ax_wr(AX_CTL, 8'h00);
            ax_wr(AX_CFG, rows[i].cfg);
            n0 = clr_n;
            ax_wr(AX_CTL, 8'h08);
            repeat (2) @(posedge clk_i);
            chk(32'({eye, xcvr, fs, dp, dm, pp_mode}), 32'(rows[i].exp), "cfg outs");
            chk(32'({attach, pkt_run, sie_clk}), 7, "enabled outs");
            chk(clr_n, n0 + 1, "pointer clear pulse");
            ax_rd(AX_CFG);
            chk(rv, 32'(rows[i].cfg), "cfg read");
        end
        ax_wr(AX_CFG, 8'h14);
        ax_rd(AX_CFG);
        chk(rv, 32'h87, "cfg locked");
        chk(32'(br), 0, "locked write answered");
        ax_wr(4'h2, 8'hff);
        chk(32'(br), 2, "unmapped write");
        ax_rd(4'h2);
        chk(32'(rr), 2, "unmapped read");
        chk(rv, 0, "unmapped reads zero");
        ax_wr(AX_CTL, 8'h48);
        chk(32'(pp_even), 1, "force even");
        ax_rd(AX_CTL);
        chk(rv & 32'h48, 32'h48, "reset sticky");
        ax_wr(AX_CTL, 8'h00);
        ax_wr(AX_CFG, 8'h74);
        ax_rd(AX_CFG);
        chk(rv, 32'h14, "reserved bits zero");
        ax_wr(AX_CTL, 8'h48);
        chk(32'(pp_even), 0, "no ping-pong");
        ax_wr(AX_CTL, 8'h08);
        $display("config table done");
        @(posedge clk_i);
        setup <= 1;
        @(posedge clk_i);
        setup <= 0;
        repeat (2) @(posedge clk_i);
        chk(32'(pkt_run), 0, "setup halts");
        ax_rd(AX_CTL);
        chk(rv & 32'h10, 32'h10, "setup flag");
        ax_wr(AX_CTL, 8'h08);
        chk(32'(pkt_run), 1, "cleared runs");
        ax_wr(AX_CTL, 8'h18);
        ax_rd(AX_CTL);
        chk(rv & 32'h10, 0, "write one ignored");
        fork
            ax_wr(AX_CTL, 8'h08);
            begin
                repeat (2) @(posedge clk_i);
                setup <= 1;
                @(posedge clk_i);
                setup <= 0;
            end
        join
        ax_rd(AX_CTL);
        chk(rv & 32'h10, 32'h10, "set beats clear");
        ax_wr(AX_CTL, 8'h08);
        chk(32'(pkt_run), 1, "cleared again");
        se0 <= 1;
        repeat (3) @(posedge clk_i);
        ax_rd(AX_CTL);
        chk(32'(rv[5]), 1, "se0 high");
        se0 <= 0;
        repeat (3) @(posedge clk_i);
        ax_rd(AX_CTL);
        chk(32'(rv[5]), 0, "se0 low");
        ax_wr(AX_CTL, 8'h0a);
        chk(32'(sie_clk), 1, "suspend refused");
        idle <= 1;
        ax_wr(AX_CTL, 8'h0a);
        chk(32'({sie_clk, tx_idle, attach}), 3, "suspended");
        ax_wr(AX_CTL, 8'h08);
        chk(32'(sie_clk), 1, "woken");
        ax_wr(AX_CTL, 8'h0c);
        chk(32'(resume), 1, "resume on");
        ax_wr(AX_TIME, 8'h01);
        ax_rd(AX_STAT);
        chk(rv, 1, "hold busy");
        for (n = 0; n < 100 && resume !== 1'b0; n++) @(posedge clk_i);
        chk(32'(n >= RS - 4 && n <= RS + 6), 1, "resume hold");
        ax_rd(AX_STAT);
        chk(rv, 0, "hold done");
        $display("engine events done");
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        ax_rd(AX_CTL);
        chk(32'({rv[7:0], attach}), 0, "second reset");
        summarize();
    end
endmodule : usb_sie_control_config_tb
`default_nettype wire
